// file: pkg/psr_pkg.sv
// What this block does
// - The summary status word answers at management register address 0x10.
// - Bit 15 is reserved: writes ignored, always reads 0.
// - Bit 14 reports crossover: 1 pairs swapped, 0 normal assignment.
// - Crossover bit follows enable and force; tracks auto swapping when enabled, unforced.
// - Bit 13 latches high on receive error; cleared by reading address 15h.
// - Bit 12 mirrors ten-megabit polarity flag; never cleared by reading this word.
// - Bit 11 latches high on false carrier; cleared by reading address 14h.
// - Bit 10 is latched-low qualified signal detect, optionally ANDed with descrambler lock.
// - Bit 9 is latched-low descrambler lock.
// - Bit 8 copies page-received flag; reading this word does not clear it.
// - Bit 7 shows pending interrupt; cleared by the interrupt status read.
// - Bit 6 sets on partner remote fault; clears on reading address 01h or reset.
// - Bit 5 copies jabber detect; reading this word does not clear it.
// - Bit 4 reads 1 once auto-negotiation completed.
// - Bit 3 reads 1 while loopback is enabled.
// - Bit 2 reports resolved duplex, 1 full, 0 half.
// - Bit 0 copies link status; reading this word does not clear it.
package psr_pkg;

  // Management register addresses seen by this block
  localparam logic [4:0] PSR_ADDR_BASIC_STATUS = 5'h01;
  localparam logic [4:0] PSR_ADDR_SUMMARY      = 5'h10;
  localparam logic [4:0] PSR_ADDR_FC_COUNT     = 5'h14;
  localparam logic [4:0] PSR_ADDR_RX_ERR_COUNT = 5'h15;

  // Field positions inside the summary word
  localparam int PSR_BIT_RESERVED  = 15;
  localparam int PSR_BIT_CROSSOVER = 14;
  localparam int PSR_BIT_RX_ERR    = 13;
  localparam int PSR_BIT_POLARITY  = 12;
  localparam int PSR_BIT_FALSE_CAR = 11;
  localparam int PSR_BIT_SIG_DET   = 10;
  localparam int PSR_BIT_DESC_LOCK = 9;
  localparam int PSR_BIT_PAGE_RX   = 8;
  localparam int PSR_BIT_INT_PEND  = 7;
  localparam int PSR_BIT_REM_FAULT = 6;
  localparam int PSR_BIT_JABBER    = 5;
  localparam int PSR_BIT_AN_DONE   = 4;
  localparam int PSR_BIT_LOOPBACK  = 3;
  localparam int PSR_BIT_DUPLEX    = 2;
  localparam int PSR_BIT_SPEED10   = 1;
  localparam int PSR_BIT_LINK      = 0;

  // Reset values
  localparam logic [15:0] PSR_RDATA_RST = 16'h0000;
  localparam logic        PSR_FLAG_RST  = 1'b0;

  // Live conditions from link monitor, negotiation, PCS and interrupt logic
  typedef struct packed {
    logic crossover_enable;
    logic crossover_force;
    logic auto_swap;
    logic polarity_inverted;
    logic signal_detect_raw;
    logic descrambler_lock;
    logic sd_qualify_en;
    logic page_received;
    logic interrupt_pending;
    logic jabber;
    logic an_complete;
    logic loopback;
    logic duplex_full;
    logic speed_10;
    logic link_up;
  } psr_live_t;

  // One-cycle events that set sticky bits
  typedef struct packed {
    logic rx_error;
    logic false_carrier;
    logic remote_fault;
  } psr_event_t;

endpackage : psr_pkg

// file: src/psr_status_summary.sv
`timescale 1ns/10ps
module psr_status_summary (
  input  wire logic             clk,
  input  wire logic             rstn,
  input  wire logic [4:0]       reg_addr,
  input  wire logic             reg_rd,
  output logic      [15:0]      reg_rdata,
  output logic                  reg_rd_hit,
  input  wire psr_pkg::psr_live_t  live,
  input  wire psr_pkg::psr_event_t evt
);

  // Decoded reads; other registers live elsewhere but their reads clear our copies
  logic rd_summary;
  logic rd_rx_err_cnt;
  logic rd_fc_cnt;
  logic rd_basic_status;

  assign rd_summary      = reg_rd && (reg_addr == psr_pkg::PSR_ADDR_SUMMARY);
  assign rd_rx_err_cnt   = reg_rd && (reg_addr == psr_pkg::PSR_ADDR_RX_ERR_COUNT);
  assign rd_fc_cnt       = reg_rd && (reg_addr == psr_pkg::PSR_ADDR_FC_COUNT);
  assign rd_basic_status = reg_rd && (reg_addr == psr_pkg::PSR_ADDR_BASIC_STATUS);

  // Crossover state: force wins, otherwise the auto algorithm if enabled
  logic crossover_now;
  assign crossover_now = live.crossover_force ? 1'b1 :
                         (live.crossover_enable ? live.auto_swap : 1'b0);

  // Signal detect as the link monitor sees it
  logic qualified_sd;
  assign qualified_sd = live.signal_detect_raw &&
                        (live.descrambler_lock || !live.sd_qualify_en);

  // Sticky receive error; a new event in the clearing cycle still sets it
  logic rx_err_reg;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rx_err_reg <= psr_pkg::PSR_FLAG_RST;
    end else if (evt.rx_error) begin
      rx_err_reg <= 1'b1;
    end else if (rd_rx_err_cnt) begin
      rx_err_reg <= 1'b0;
    end
  end

  // Sticky false carrier, same set-over-clear priority
  logic false_car_reg;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      false_car_reg <= psr_pkg::PSR_FLAG_RST;
    end else if (evt.false_carrier) begin
      false_car_reg <= 1'b1;
    end else if (rd_fc_cnt) begin
      false_car_reg <= 1'b0;
    end
  end

  // Remote fault held until the basic status register is read
  logic rem_fault_reg;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rem_fault_reg <= psr_pkg::PSR_FLAG_RST;
    end else if (evt.remote_fault) begin
      rem_fault_reg <= 1'b1;
    end else if (rd_basic_status) begin
      rem_fault_reg <= 1'b0;
    end
  end

  // Latched-low bits: a drop sticks until this word is read, then re-arm on live.
  // They start at 0 after reset, so the first read shows the reset drop.
  logic sd_ll_reg;
  logic lock_ll_reg;
  logic sd_ll_next;
  logic lock_ll_next;
  assign sd_ll_next   = qualified_sd && (sd_ll_reg || rd_summary);
  assign lock_ll_next = live.descrambler_lock && (lock_ll_reg || rd_summary);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sd_ll_reg   <= psr_pkg::PSR_FLAG_RST;
      lock_ll_reg <= psr_pkg::PSR_FLAG_RST;
    end else begin
      sd_ll_reg   <= sd_ll_next;
      lock_ll_reg <= lock_ll_next;
    end
  end

  // Assembled word; copies are plain mirrors so reading here never clears them
  logic [15:0] summary_word;
  always_comb begin
    summary_word = psr_pkg::PSR_RDATA_RST;
    summary_word[psr_pkg::PSR_BIT_RESERVED]  = 1'b0;
    summary_word[psr_pkg::PSR_BIT_CROSSOVER] = crossover_now;
    summary_word[psr_pkg::PSR_BIT_RX_ERR]    = rx_err_reg;
    summary_word[psr_pkg::PSR_BIT_POLARITY]  = live.polarity_inverted;
    summary_word[psr_pkg::PSR_BIT_FALSE_CAR] = false_car_reg;
    summary_word[psr_pkg::PSR_BIT_SIG_DET]   = sd_ll_reg;
    summary_word[psr_pkg::PSR_BIT_DESC_LOCK] = lock_ll_reg;
    summary_word[psr_pkg::PSR_BIT_PAGE_RX]   = live.page_received;
    summary_word[psr_pkg::PSR_BIT_INT_PEND]  = live.interrupt_pending;
    summary_word[psr_pkg::PSR_BIT_REM_FAULT] = rem_fault_reg;
    summary_word[psr_pkg::PSR_BIT_JABBER]    = live.jabber;
    summary_word[psr_pkg::PSR_BIT_AN_DONE]   = live.an_complete;
    summary_word[psr_pkg::PSR_BIT_LOOPBACK]  = live.loopback;
    summary_word[psr_pkg::PSR_BIT_DUPLEX]    = live.duplex_full;
    summary_word[psr_pkg::PSR_BIT_SPEED10]   = live.speed_10;
    summary_word[psr_pkg::PSR_BIT_LINK]      = live.link_up;
  end

  // Read data captured on the strobe and held until the next summary read
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= psr_pkg::PSR_RDATA_RST;
    end else if (rd_summary) begin
      reg_rdata <= summary_word;
    end
  end

  // One-cycle marker that reg_rdata carries a fresh summary word
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      reg_rd_hit <= 1'b0;
    end else begin
      reg_rd_hit <= rd_summary;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  // Summary read answers next cycle with the word seen at the strobe
  property p_read_answer;
    rd_summary |=> reg_rd_hit && (reg_rdata == $past(summary_word));
  endproperty
  a_read_answer: assert property (p_read_answer) else $error("summary read answer wrong");

  // Reserved bit never reads 1
  property p_reserved_zero;
    reg_rd_hit |-> !reg_rdata[15];
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

  // Crossover bit against enable, force and auto state
  property p_crossover;
    rd_summary |=> reg_rdata[14] == ($past(live.crossover_force) ||
      ($past(live.crossover_enable) && $past(live.auto_swap)));
  endproperty
  a_crossover: assert property (p_crossover) else $error("crossover bit wrong");

  // Receive error sets at once and survives until its counter read
  property p_rx_err_hold;
    (evt.rx_error || (rx_err_reg && !rd_rx_err_cnt)) |=> rx_err_reg;
  endproperty
  a_rx_err_hold: assert property (p_rx_err_hold) else $error("rx error latch lost");

  // False carrier clears only through its own counter read
  property p_fc_clear;
    $fell(false_car_reg) |-> $past(rd_fc_cnt) && !$past(evt.false_carrier);
  endproperty
  a_fc_clear: assert property (p_fc_clear) else $error("false carrier cleared wrongly");

  // Qualified detect drop is caught and held through the following quiet cycle
  property p_sd_low_hold;
    !qualified_sd ##1 !rd_summary |-> !sd_ll_reg [*2];
  endproperty
  a_sd_low_hold: assert property (p_sd_low_hold) else $error("signal detect low lost");

  // Lock bit can rise only after a summary read with lock present
  property p_lock_rise;
    $rose(lock_ll_reg) |-> $past(rd_summary) && $past(live.descrambler_lock);
  endproperty
  a_lock_rise: assert property (p_lock_rise) else $error("lock bit re-armed early");

  // Remote fault clears only on a basic status read without a new fault
  property p_rem_fault;
    $fell(rem_fault_reg) |-> $past(rd_basic_status) && !$past(evt.remote_fault);
  endproperty
  a_rem_fault: assert property (p_rem_fault) else $error("remote fault cleared wrongly");

  // Mirrored copies read back as the live inputs at the strobe
  property p_copies;
    rd_summary |=> reg_rdata[12] == $past(live.polarity_inverted) &&
      reg_rdata[8] == $past(live.page_received) &&
      reg_rdata[7] == $past(live.interrupt_pending) &&
      reg_rdata[5] == $past(live.jabber) && reg_rdata[0] == $past(live.link_up);
  endproperty
  a_copies: assert property (p_copies) else $error("mirrored bit mismatch");

  // Negotiation, loopback, duplex and speed fields
  property p_mode_bits;
    rd_summary |=> reg_rdata[4:1] == {$past(live.an_complete), $past(live.loopback),
      $past(live.duplex_full), $past(live.speed_10)};
  endproperty
  a_mode_bits: assert property (p_mode_bits) else $error("mode bits mismatch");

  // A hit marker only ever follows a summary read
  property p_hit_src;
    reg_rd_hit |-> $past(rd_summary);
  endproperty
  a_hit_src: assert property (p_hit_src) else $error("hit without summary read");

  // Held read data moves only on a summary read, so other reads cannot disturb it
  property p_rdata_hold;
    !rd_summary |=> $stable(reg_rdata);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved");

  // Receive error drops only through its counter read with no event in that cycle
  property p_rx_err_clr;
    $fell(rx_err_reg) |-> $past(rd_rx_err_cnt) && !$past(evt.rx_error);
  endproperty
  a_rx_err_clr: assert property (p_rx_err_clr) else $error("rx error cleared wrongly");

  // False carrier sets at once and survives reads of other addresses
  property p_fc_hold;
    (evt.false_carrier || (false_car_reg && !rd_fc_cnt)) |=> false_car_reg;
  endproperty
  a_fc_hold: assert property (p_fc_hold) else $error("false carrier latch lost");

  // Remote fault sets at once and survives until the basic status read
  property p_rf_hold;
    (evt.remote_fault || (rem_fault_reg && !rd_basic_status)) |=> rem_fault_reg;
  endproperty
  a_rf_hold: assert property (p_rf_hold) else $error("remote fault latch lost");

  // Without raw detect the qualified copy must go low
  property p_sd_raw;
    !live.signal_detect_raw |=> !sd_ll_reg;
  endproperty
  a_sd_raw: assert property (p_sd_raw) else $error("detect high without raw");

  // With qualification on, losing lock also drops the detect copy
  property p_sd_lock;
    live.sd_qualify_en && !live.descrambler_lock |=> !sd_ll_reg;
  endproperty
  a_sd_lock: assert property (p_sd_lock) else $error("detect high without lock");

  // A summary read re-arms detect from live; lock is ignored when unqualified
  property p_sd_rearm;
    rd_summary && live.signal_detect_raw &&
      (live.descrambler_lock || !live.sd_qualify_en) |=> sd_ll_reg;
  endproperty
  a_sd_rearm: assert property (p_sd_rearm) else $error("detect not re-armed");

  // Lock drop is caught and held through the following quiet cycle
  property p_lock_low_hold;
    !live.descrambler_lock ##1 !rd_summary |-> !lock_ll_reg [*2];
  endproperty
  a_lock_low_hold: assert property (p_lock_low_hold) else $error("lock low lost");

  // Lock copy is low the cycle after live lock is absent
  property p_lock_live;
    !live.descrambler_lock |=> !lock_ll_reg;
  endproperty
  a_lock_live: assert property (p_lock_live) else $error("lock high without lock");

  // A summary read with lock present re-arms the lock copy
  property p_lock_rearm;
    rd_summary && live.descrambler_lock |=> lock_ll_reg;
  endproperty
  a_lock_rearm: assert property (p_lock_rearm) else $error("lock not re-armed");

  // Polarity copy reads as its source at the strobe
  property p_polarity;
    rd_summary |=> reg_rdata[psr_pkg::PSR_BIT_POLARITY] == $past(live.polarity_inverted);
  endproperty
  a_polarity: assert property (p_polarity) else $error("polarity bit mismatch");

  // Page received copy reads as its source; this read leaves the source alone
  property p_page_rx;
    rd_summary |=> reg_rdata[psr_pkg::PSR_BIT_PAGE_RX] == $past(live.page_received);
  endproperty
  a_page_rx: assert property (p_page_rx) else $error("page received mismatch");

  // Pending interrupt reads as the interrupt logic shows it
  property p_int_pend;
    rd_summary |=> reg_rdata[psr_pkg::PSR_BIT_INT_PEND] == $past(live.interrupt_pending);
  endproperty
  a_int_pend: assert property (p_int_pend) else $error("interrupt bit mismatch");

  // Link bit reads as the live link status
  property p_link;
    rd_summary |=> reg_rdata[psr_pkg::PSR_BIT_LINK] == $past(live.link_up);
  endproperty
  a_link: assert property (p_link) else $error("link bit mismatch");

  // Negotiation done bit reads as its source
  property p_an_done;
    rd_summary |=> reg_rdata[psr_pkg::PSR_BIT_AN_DONE] == $past(live.an_complete);
  endproperty
  a_an_done: assert property (p_an_done) else $error("negotiation bit mismatch");

  // Loopback bit reads as its source
  property p_loopback;
    rd_summary |=> reg_rdata[psr_pkg::PSR_BIT_LOOPBACK] == $past(live.loopback);
  endproperty
  a_loopback: assert property (p_loopback) else $error("loopback bit mismatch");

  // Speed bit reads 1 for ten megabit, as resolved
  property p_speed;
    rd_summary |=> reg_rdata[psr_pkg::PSR_BIT_SPEED10] == $past(live.speed_10);
  endproperty
  a_speed: assert property (p_speed) else $error("speed bit mismatch");

endmodule : psr_status_summary

// file: verif/psr_mgmt_model.sv
`timescale 1ns/10ps
module psr_mgmt_model (
  input  wire logic        clk,
  input  wire logic [15:0] reg_rdata,
  input  wire logic        reg_rd_hit,
  output logic             reg_rd,
  output logic [4:0]       reg_addr
);
  logic [15:0] last_word;
  logic        speed_ok;

  // Idle address is the inverse of the last one, so no stale value looks live
  initial begin
    reg_rd    = 1'b0;
    reg_addr  = 5'h1f;
    last_word = 16'h0000;
    speed_ok  = 1'b0;
  end

  // One read: strobe one cycle, answer captured the cycle after
  task automatic rd(input logic [4:0] a);
    @(posedge clk);
    #1;
    reg_rd   = 1'b1;
    reg_addr = a;
    @(posedge clk);
    #1;
    reg_rd   = 1'b0;
    reg_addr = ~a;
    // Speed and duplex are trusted only with link up and negotiation done
    if (reg_rd_hit === 1'b1) begin
      last_word = reg_rdata;
      speed_ok  = reg_rdata[psr_pkg::PSR_BIT_LINK] & reg_rdata[psr_pkg::PSR_BIT_AN_DONE];
    end
  endtask : rd
endmodule : psr_mgmt_model

// file: verif/psr_status_summary_tb.sv
`timescale 1ns/10ps
module psr_status_summary_tb;
  logic                clk;
  logic                rstn;
  logic [4:0]          reg_addr;
  logic                reg_rd;
  logic [15:0]         reg_rdata;
  logic                reg_rd_hit;
  psr_pkg::psr_live_t  live;
  psr_pkg::psr_event_t evt;
  int                  err_total;
  int                  compares;
  logic                ll_sd;
  logic                ll_lk;
  logic [15:0]         stk;
  logic [4:0]          clr_addr [3];
  int                  stk_bit  [3];

  psr_status_summary u_dut (.clk(clk), .rstn(rstn), .reg_addr(reg_addr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reg_rd_hit(reg_rd_hit), .live(live), .evt(evt));
  psr_mgmt_model u_mgmt (.clk(clk), .reg_rdata(reg_rdata), .reg_rd_hit(reg_rd_hit),
    .reg_rd(reg_rd), .reg_addr(reg_addr));

  // Expected word; latched-low copies reload from live on each summary read
  function automatic logic [15:0] exp_word();
    logic        q;
    logic [15:0] w;
    q = live.signal_detect_raw & (live.descrambler_lock | ~live.sd_qualify_en);
    w = stk;
    w[14] = live.crossover_force | (live.crossover_enable & live.auto_swap);
    w[12] = live.polarity_inverted;
    w[10] = ll_sd & q;
    w[9] = ll_lk & live.descrambler_lock;
    w[8:7] = {live.page_received, live.interrupt_pending};
    w[5:0] = {live.jabber, live.an_complete, live.loopback, live.duplex_full,
              live.speed_10, live.link_up};
    ll_sd = q;
    ll_lk = live.descrambler_lock;
    return w;
  endfunction : exp_word

  task automatic chk(input logic ok, input string msg);
    compares++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("BAD %0t %s", $time, msg);
    end
  endtask : chk

  task automatic rd_sum();
    logic [15:0] e;
    e = exp_word();
    u_mgmt.rd(psr_pkg::PSR_ADDR_SUMMARY);
    chk(reg_rd_hit === 1'b1 && reg_rdata === e, "summary word");
    chk(u_mgmt.speed_ok === (e[0] & e[4]), "speed trust flag");
  endtask : rd_sum

  // Other addresses must neither answer nor disturb the held word
  task automatic rd_other(input logic [4:0] a);
    logic [15:0] keep;
    keep = reg_rdata;
    u_mgmt.rd(a);
    chk(reg_rd_hit === 1'b0 && reg_rdata === keep, "answer off address");
  endtask : rd_other

  task automatic conclude();
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : conclude

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // Whole run is about 93 cycles; this limit of 5000 cycles is over fifty times that
  initial begin
    #40000;
    err_total++;
    conclude();
  end

  initial begin
    {rstn, ll_sd, ll_lk} = 3'b000;
    err_total = 0;
    compares = 0;
    live = '0;
    evt = '0;
    stk = 16'h0000;
    clr_addr = '{psr_pkg::PSR_ADDR_RX_ERR_COUNT, psr_pkg::PSR_ADDR_FC_COUNT,
                 psr_pkg::PSR_ADDR_BASIC_STATUS};
    stk_bit = '{psr_pkg::PSR_BIT_RX_ERR, psr_pkg::PSR_BIT_FALSE_CAR, psr_pkg::PSR_BIT_REM_FAULT};
    repeat (3) @(posedge clk);
    #1 rstn = 1'b1;
    chk(reg_rdata === 16'h0000 && reg_rd_hit === 1'b0, "reset value");
    // Patterns sweep every live field and all crossover settings
    for (int k = 0; k < 16; k++) begin
      live = psr_pkg::psr_live_t'(15'(k * 'h0923) ^ 15'h5a5a);
      rd_sum();
    end
    // A short drop of lock is held until the next summary read
    live = '0;
    {live.signal_detect_raw, live.descrambler_lock, live.sd_qualify_en} = 3'b111;
    rd_sum();
    rd_sum();
    live.descrambler_lock = 1'b0;
    repeat (2) @(posedge clk);
    #1 live.descrambler_lock = 1'b1;
    {ll_sd, ll_lk} = 2'b00;
    rd_sum();
    rd_sum();
    // Sticky bits: summary reads keep them, own clear read drops them, an event beats its clear
    for (int i = 0; i < 3; i++) begin
      evt = psr_pkg::psr_event_t'(3'b100 >> i);
      @(posedge clk);
      #1 evt = '0;
      stk[stk_bit[i]] = 1'b1;
      rd_sum();
      rd_sum();
      fork
        rd_other(clr_addr[i]);
        begin
          @(posedge clk);
          #1 evt = psr_pkg::psr_event_t'(3'b100 >> i);
          @(posedge clk);
          #1 evt = '0;
        end
      join
      rd_sum();
      rd_other(clr_addr[i]);
      stk[stk_bit[i]] = 1'b0;
      rd_sum();
    end
    // Reset mid-run clears a pending remote fault and both latched-low copies;
    // it spans two edges so no check sees a half-reset history
    evt.remote_fault = 1'b1;
    @(posedge clk);
    #1 evt = '0;
    stk[psr_pkg::PSR_BIT_REM_FAULT] = 1'b1;
    rd_sum();
    rstn = 1'b0;
    repeat (2) @(posedge clk);
    #1 rstn = 1'b1;
    chk(reg_rdata === 16'h0000 && reg_rd_hit === 1'b0, "mid-run reset");
    {ll_sd, ll_lk} = 2'b00;
    stk = 16'h0000;
    rd_sum();
    rd_sum();
    conclude();
  end
endmodule : psr_status_summary_tb
